// >>> bsi_pkg.sv
// Shared types and constants for the binary input safety interlock.
// Assumes a single 10 MHz system clock and an active-low async reset.

package bsi_pkg;

	// ============================================================
	// Types
	typedef enum logic [1:0] {BSI_POL_NO, BSI_POL_NC, BSI_POL_UNUSED}
		bsi_pol_t;
	typedef enum logic [1:0] {BSI_OCC_OCCUPIED, BSI_OCC_STANDBY,
		BSI_OCC_UNOCC} bsi_occ_t;
	typedef enum logic [1:0] {BSI_VOVR_NONE, BSI_VOVR_OPEN,
		BSI_VOVR_CLOSE} bsi_vovr_t;
	typedef enum logic [2:0] {BSI_TST_IDLE, BSI_TST_FAN, BSI_TST_VLV_OPEN,
		BSI_TST_VLV_CLOSE, BSI_TST_COMP, BSI_TST_HEAT,
		BSI_TST_DAMPER} bsi_test_t;

	// ============================================================
	// Input positions
	localparam int BSI_NUM_INPUTS = 4;
	localparam int BSI_IDX_FREEZE = 0;
	localparam int BSI_IDX_CONDENSATE = 1;
	localparam int BSI_IDX_SPARE = 2;
	localparam int BSI_IDX_FAN_PROOF = 3;

	// ============================================================
	// Timing
	localparam int BSI_CLK_HZ = 10_000_000;
	localparam int BSI_FAN_PROOF_TIME_S = 60;
	localparam logic [31:0] BSI_FAN_PROOF_CYCLES =
		32'(longint'(BSI_FAN_PROOF_TIME_S) * longint'(BSI_CLK_HZ));
	localparam int BSI_AUTO_RECOVER_TIME_S = 300;
	localparam logic [31:0] BSI_AUTO_RECOVER_CYCLES =
		32'(longint'(BSI_AUTO_RECOVER_TIME_S) * longint'(BSI_CLK_HZ));
	localparam logic [1:0] BSI_AUTO_RETRY_MAX = 2'h3;

	// ============================================================
	// Reset values
	localparam logic BSI_BIT_RST = 1'b0;
	localparam logic [1:0] BSI_RETRY_RST = 2'h0;
	localparam logic [31:0] BSI_CNT_RST = 32'h0000_0000;
	localparam logic [3:0] BSI_NIB_RST = 4'h0;

endpackage

// >>> bsi_link_if.sv
// Carrier between the contact conditioner, fan proof timer and core.
// Assumes all parties run on the same system clock.

`timescale 1ns/1ps

interface bsi_link_if;
	logic [3:0] asserted;       // Conditioned contacts, 1 = active
	logic       fan_cmd;        // Fan actually commanded on
	logic       fan_proof_used; // Fan proof input configured in use
	logic       fan_fail_evt;   // One-cycle fan proof timeout

	modport cond (output asserted);
	modport timer (input asserted, input fan_cmd, input fan_proof_used,
		output fan_fail_evt);
	modport core (input asserted, input fan_fail_evt,
		output fan_cmd, output fan_proof_used);
endinterface

// >>> bsi_contact_cond.sv
// Contact conditioner: synchronises the four contact pins and maps each
// through its polarity setting. Assumes pins are high when closed.

`timescale 1ns/1ps

module bsi_contact_cond
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Contacts and configuration
	input  wire logic [3:0]       contact_closed,
	input  wire bsi_pkg::bsi_pol_t pol [4],
	// Conditioned result
	bsi_link_if.cond              lk
);

	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] asserted_reg;
	logic [3:0] asserted_next;
	logic       prime1_reg;
	logic       prime2_reg;

	// ============================================================
	// Polarity mapping, one slice per input
	for (genvar i = 0; i < bsi_pkg::BSI_NUM_INPUTS; i++)
	begin : g_in
		// Unused inputs read as idle so they never trip anything; all
		// inputs stay idle until the synchroniser holds a real pin sample,
		// since its reset zeros look like an open safety contact
		always_comb
		begin
			if (!prime2_reg)
				asserted_next[i] = 1'b0;
			else
				unique case (pol[i])
					bsi_pkg::BSI_POL_NO:     asserted_next[i] = sync2_reg[i];
					bsi_pkg::BSI_POL_NC:     asserted_next[i] = !sync2_reg[i];
					bsi_pkg::BSI_POL_UNUSED: asserted_next[i] = 1'b0;
					default:                 asserted_next[i] = 1'b0;
				endcase
		end

		AST_UNUSED_IDLE:
		assert property (@(posedge clk) disable iff (!rst_n)
			(pol[i] == bsi_pkg::BSI_POL_UNUSED) |=> !asserted_reg[i])
		else $error("unused contact reads active");
	end

	// Two-stage synchroniser then registered result
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_reg    <= bsi_pkg::BSI_NIB_RST;
			sync2_reg    <= bsi_pkg::BSI_NIB_RST;
			asserted_reg <= bsi_pkg::BSI_NIB_RST;
			prime1_reg   <= bsi_pkg::BSI_BIT_RST;
			prime2_reg   <= bsi_pkg::BSI_BIT_RST;
		end
		else
		begin
			sync1_reg    <= contact_closed;
			sync2_reg    <= sync1_reg;
			asserted_reg <= asserted_next;
			prime1_reg   <= 1'b1;
			prime2_reg   <= prime1_reg;
		end
	end

	assign lk.asserted = asserted_reg;

	AST_NC_INVERTS:
	assert property (@(posedge clk) disable iff (!rst_n)
		prime2_reg && (pol[0] == bsi_pkg::BSI_POL_NC) |=>
		(asserted_reg[0] == !$past(sync2_reg[0])))
	else $error("normally closed contact not inverted");

endmodule

// >>> bsi_fan_timer.sv
// Fan proof timer: counts while the fan is commanded and the proof
// contact is open. Assumes the limit parameter is at least two.

`timescale 1ns/1ps

module bsi_fan_timer
#(
	parameter logic [31:0] LIMIT = bsi_pkg::BSI_FAN_PROOF_CYCLES
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Link to the core
	bsi_link_if.timer lk
);

	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        cmd_d_reg;
	logic        evt_reg;
	logic        evt_next;
	logic        restart;

	// ============================================================
	// Counter; it saturates at the limit so one timeout gives one pulse
	always_comb
	begin
		restart  = !lk.fan_cmd || !lk.fan_proof_used ||
			lk.asserted[bsi_pkg::BSI_IDX_FAN_PROOF] ||
			(lk.fan_cmd && !cmd_d_reg);
		cnt_next = cnt_reg;
		evt_next = 1'b0;
		if (restart)
			cnt_next = bsi_pkg::BSI_CNT_RST;
		else if (cnt_reg != LIMIT)
		begin
			cnt_next = cnt_reg + 32'h1;
			evt_next = (cnt_reg == LIMIT - 32'h1);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg   <= bsi_pkg::BSI_CNT_RST;
			cmd_d_reg <= bsi_pkg::BSI_BIT_RST;
			evt_reg   <= bsi_pkg::BSI_BIT_RST;
		end
		else
		begin
			cnt_reg   <= cnt_next;
			cmd_d_reg <= lk.fan_cmd;
			evt_reg   <= evt_next;
		end
	end

	assign lk.fan_fail_evt = evt_reg;

	AST_FAN_EVT_CAUSE:
	assert property (@(posedge clk) disable iff (!rst_n)
		evt_reg |-> $past(lk.fan_cmd) &&
		!$past(lk.asserted[bsi_pkg::BSI_IDX_FAN_PROOF]) &&
		($past(cnt_reg) == LIMIT - 32'h1))
	else $error("fan failure without a full open interval");

	AST_FAN_RESTART:
	assert property (@(posedge clk) disable iff (!rst_n)
		lk.asserted[bsi_pkg::BSI_IDX_FAN_PROOF] |=> (cnt_reg == 32'h0))
	else $error("proof closure did not restart the timer");

endmodule

// >>> bsi_interlock.sv
// Binary input safety interlock core: latched diagnostics, safe output
// forcing, occupancy arbitration, manual test and valve override.
// Assumes command inputs come from logic on CLK; contacts and the test
// button are asynchronous pins.
//
// Overview of operation
// - Four contact inputs, each independently normally open or closed.
// - Not-used setting removes an input from control and diagnostics.
// - Third input is occupancy or generic; generic never steers outputs.
// - Freeze contact open raises the low coil temperature diagnostic.
// - Condensate float open raises the condensate overflow diagnostic.
// - Stand-alone: occupancy contact closed means unoccupied, open occupied.
// - Communicated occupancy request takes precedence over the contact.
// - Condensate diagnostic stops fan, valves, compressor, heat and damper.
// - Condensate diagnostic stays latched until a manual reset.
// - Low coil diagnostic stops fan, opens valves, closes damper.
// - Low coil diagnostic stays latched until a reset or an automatic recovery.
// - Automatic recovery tries to clear the low coil diagnostic.
// - Fan failure when commanded on and proof open for one minute.
// - Fan failure when proof fails to close one minute after start.
// - Fan failure latches and halts fan, valves and damper.
// - Generic output follows only its communicated command.
// - Manual test starts by button or comms, steps outputs in sequence.
// - Water valve override forces valves fully open or fully closed.
// - Open occupancy contact with communicated occupied gives occupied.

`timescale 1ns/1ps

module bsi_interlock
#(
	parameter logic [31:0] FAN_PROOF_CYCLES    = bsi_pkg::BSI_FAN_PROOF_CYCLES,
	parameter logic [31:0] AUTO_RECOVER_CYCLES =
		bsi_pkg::BSI_AUTO_RECOVER_CYCLES
)
(
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                RST_N,
	// Field contacts and local button, asynchronous
	input  wire logic [3:0]          CONTACT_CLOSED,
	input  wire logic                TEST_BUTTON,
	// Configuration
	input  wire bsi_pkg::bsi_pol_t   CFG_POL [4],
	input  wire logic                CFG_SPARE_GENERIC,
	// Normal control requests
	input  wire logic                FAN_REQ,
	input  wire logic                VALVE_REQ,
	input  wire logic                COMP_REQ,
	input  wire logic                HEAT_REQ,
	input  wire logic                DAMPER_REQ,
	input  wire logic                GENERIC_REQ,
	// Communicated requests
	input  wire logic                COMM_OCC_VALID,
	input  wire bsi_pkg::bsi_occ_t   COMM_OCC_REQ,
	input  wire logic                COMM_TEST,
	input  wire bsi_pkg::bsi_vovr_t  VALVE_OVERRIDE,
	input  wire logic                DIAG_RESET,
	// Unit outputs
	output logic                     FAN_ON,
	output logic                     WATER_VALVE_OPEN,
	output logic                     COMPRESSOR_ON,
	output logic                     ELEC_HEAT_ON,
	output logic                     OA_DAMPER_OPEN,
	output logic                     GENERIC_OUT,
	// Status
	output bsi_pkg::bsi_occ_t        OCC_MODE,
	output logic                     LOW_COIL_DIAG,
	output logic                     CONDENSATE_DIAG,
	output logic                     FAN_FAILURE_DIAG,
	output logic                     SPARE_INPUT_STATE,
	output logic                     TEST_ACTIVE
);

	bsi_link_if lk ();

	logic coil_freeze_input;
	logic condensate_input;
	logic occupancy_or_spare_input;
	logic fan_proof_input;

	// ============================================================
	// Input conditioning and fan proof timing
	bsi_contact_cond u_cond
	(
		.clk            (CLK),
		.rst_n          (RST_N),
		.contact_closed (CONTACT_CLOSED),
		.pol            (CFG_POL),
		.lk             (lk.cond)
	);

	bsi_fan_timer #(.LIMIT(FAN_PROOF_CYCLES)) u_fan
	(
		.clk   (CLK),
		.rst_n (RST_N),
		.lk    (lk.timer)
	);

	// Named views of the conditioned contacts
	assign coil_freeze_input        = lk.asserted[bsi_pkg::BSI_IDX_FREEZE];
	assign condensate_input         = lk.asserted[bsi_pkg::BSI_IDX_CONDENSATE];
	assign occupancy_or_spare_input = lk.asserted[bsi_pkg::BSI_IDX_SPARE];
	assign fan_proof_input          = lk.asserted[bsi_pkg::BSI_IDX_FAN_PROOF];
	assign lk.fan_proof_used =
		CFG_POL[bsi_pkg::BSI_IDX_FAN_PROOF] != bsi_pkg::BSI_POL_UNUSED;

	// ============================================================
	// Test trigger: button synchronised, both sources edge-detected
	logic btn_s1_reg;
	logic btn_s2_reg;
	logic btn_d_reg;
	logic comm_d_reg;
	logic test_trig;

	always_comb
	begin
		test_trig = (btn_s2_reg && !btn_d_reg) || (COMM_TEST && !comm_d_reg);
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			btn_s1_reg <= bsi_pkg::BSI_BIT_RST;
			btn_s2_reg <= bsi_pkg::BSI_BIT_RST;
			btn_d_reg  <= bsi_pkg::BSI_BIT_RST;
			comm_d_reg <= bsi_pkg::BSI_BIT_RST;
		end
		else
		begin
			btn_s1_reg <= TEST_BUTTON;
			btn_s2_reg <= btn_s1_reg;
			btn_d_reg  <= btn_s2_reg;
			comm_d_reg <= COMM_TEST;
		end
	end

	// ============================================================
	// Manual test sequence: each trigger moves to the next step
	bsi_pkg::bsi_test_t test_reg;
	bsi_pkg::bsi_test_t test_next;

	always_comb
	begin
		test_next = test_reg;
		if (test_trig)
		begin
			unique case (test_reg)
				bsi_pkg::BSI_TST_IDLE:      test_next = bsi_pkg::BSI_TST_FAN;
				bsi_pkg::BSI_TST_FAN:       test_next = bsi_pkg::BSI_TST_VLV_OPEN;
				bsi_pkg::BSI_TST_VLV_OPEN:  test_next = bsi_pkg::BSI_TST_VLV_CLOSE;
				bsi_pkg::BSI_TST_VLV_CLOSE: test_next = bsi_pkg::BSI_TST_COMP;
				bsi_pkg::BSI_TST_COMP:      test_next = bsi_pkg::BSI_TST_HEAT;
				bsi_pkg::BSI_TST_HEAT:      test_next = bsi_pkg::BSI_TST_DAMPER;
				bsi_pkg::BSI_TST_DAMPER:    test_next = bsi_pkg::BSI_TST_IDLE;
				default:                    test_next = bsi_pkg::BSI_TST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			test_reg <= bsi_pkg::BSI_TST_IDLE;
		else
			test_reg <= test_next;
	end

	// ============================================================
	// Latched diagnostics; a new trip wins over a clear in the same cycle
	logic        low_coil_reg;
	logic        low_coil_next;
	logic        cond_reg;
	logic        cond_next;
	logic        fan_fail_reg;
	logic        fan_fail_next;
	logic [1:0]  retry_reg;
	logic [1:0]  retry_next;
	logic [31:0] recov_reg;
	logic [31:0] recov_next;

	always_comb
	begin
		cond_next     = cond_reg;
		low_coil_next = low_coil_reg;
		fan_fail_next = fan_fail_reg;
		retry_next    = retry_reg;
		recov_next    = bsi_pkg::BSI_CNT_RST;
		// Retries are bounded so a coil that keeps freezing needs a person
		if (low_coil_reg && !coil_freeze_input && retry_reg !=
			bsi_pkg::BSI_AUTO_RETRY_MAX)
		begin
			if (recov_reg == AUTO_RECOVER_CYCLES - 32'h1)
			begin
				low_coil_next = 1'b0;
				retry_next    = retry_reg + 2'h1;
			end
			else
				recov_next = recov_reg + 32'h1;
		end
		if (DIAG_RESET)
		begin
			cond_next     = 1'b0;
			low_coil_next = 1'b0;
			fan_fail_next = 1'b0;
			retry_next    = bsi_pkg::BSI_RETRY_RST;
		end
		if (condensate_input)
			cond_next = 1'b1;
		if (coil_freeze_input)
			low_coil_next = 1'b1;
		if (lk.fan_fail_evt)
			fan_fail_next = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cond_reg     <= bsi_pkg::BSI_BIT_RST;
			low_coil_reg <= bsi_pkg::BSI_BIT_RST;
			fan_fail_reg <= bsi_pkg::BSI_BIT_RST;
			retry_reg    <= bsi_pkg::BSI_RETRY_RST;
			recov_reg    <= bsi_pkg::BSI_CNT_RST;
		end
		else
		begin
			cond_reg     <= cond_next;
			low_coil_reg <= low_coil_next;
			fan_fail_reg <= fan_fail_next;
			retry_reg    <= retry_next;
			recov_reg    <= recov_next;
		end
	end

	// ============================================================
	// Output arbitration: normal, override, test, then diagnostics last
	logic              fan_next;
	logic              valve_next;
	logic              comp_next;
	logic              heat_next;
	logic              damper_next;
	logic              hw_unocc;
	bsi_pkg::bsi_occ_t occ_next;

	always_comb
	begin
		fan_next    = FAN_REQ;
		valve_next  = VALVE_REQ;
		comp_next   = COMP_REQ;
		heat_next   = HEAT_REQ;
		damper_next = DAMPER_REQ;
		if (VALVE_OVERRIDE == bsi_pkg::BSI_VOVR_OPEN)
			valve_next = 1'b1;
		else if (VALVE_OVERRIDE == bsi_pkg::BSI_VOVR_CLOSE)
			valve_next = 1'b0;
		if (test_reg != bsi_pkg::BSI_TST_IDLE)
		begin
			fan_next    = test_reg == bsi_pkg::BSI_TST_FAN;
			valve_next  = test_reg == bsi_pkg::BSI_TST_VLV_OPEN;
			comp_next   = test_reg == bsi_pkg::BSI_TST_COMP;
			heat_next   = test_reg == bsi_pkg::BSI_TST_HEAT;
			damper_next = test_reg == bsi_pkg::BSI_TST_DAMPER;
		end
		// Compressor and heat are dropped with the fan to avoid dead air
		if (fan_fail_reg)
		begin
			fan_next    = 1'b0;
			valve_next  = 1'b0;
			comp_next   = 1'b0;
			heat_next   = 1'b0;
			damper_next = 1'b0;
		end
		if (low_coil_reg)
		begin
			fan_next    = 1'b0;
			valve_next  = 1'b1;
			comp_next   = 1'b0;
			heat_next   = 1'b0;
			damper_next = 1'b0;
		end
		if (cond_reg)
		begin
			fan_next    = 1'b0;
			valve_next  = 1'b0;
			comp_next   = 1'b0;
			heat_next   = 1'b0;
			damper_next = 1'b0;
		end
		// Generic use or not-used leaves the contact idle, so occupied
		hw_unocc = occupancy_or_spare_input && !CFG_SPARE_GENERIC;
		if (COMM_OCC_VALID)
		begin
			unique case (COMM_OCC_REQ)
				bsi_pkg::BSI_OCC_UNOCC:   occ_next = bsi_pkg::BSI_OCC_UNOCC;
				bsi_pkg::BSI_OCC_STANDBY: occ_next = bsi_pkg::BSI_OCC_STANDBY;
				default:                  occ_next = hw_unocc ?
					bsi_pkg::BSI_OCC_STANDBY : bsi_pkg::BSI_OCC_OCCUPIED;
			endcase
		end
		else
			occ_next = hw_unocc ? bsi_pkg::BSI_OCC_UNOCC :
				bsi_pkg::BSI_OCC_OCCUPIED;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			FAN_ON            <= bsi_pkg::BSI_BIT_RST;
			WATER_VALVE_OPEN  <= bsi_pkg::BSI_BIT_RST;
			COMPRESSOR_ON     <= bsi_pkg::BSI_BIT_RST;
			ELEC_HEAT_ON      <= bsi_pkg::BSI_BIT_RST;
			OA_DAMPER_OPEN    <= bsi_pkg::BSI_BIT_RST;
			GENERIC_OUT       <= bsi_pkg::BSI_BIT_RST;
			OCC_MODE          <= bsi_pkg::BSI_OCC_OCCUPIED;
			SPARE_INPUT_STATE <= bsi_pkg::BSI_BIT_RST;
			TEST_ACTIVE       <= bsi_pkg::BSI_BIT_RST;
		end
		else
		begin
			FAN_ON            <= fan_next;
			WATER_VALVE_OPEN  <= valve_next;
			COMPRESSOR_ON     <= comp_next;
			ELEC_HEAT_ON      <= heat_next;
			OA_DAMPER_OPEN    <= damper_next;
			GENERIC_OUT       <= GENERIC_REQ;
			OCC_MODE          <= occ_next;
			SPARE_INPUT_STATE <= occupancy_or_spare_input;
			TEST_ACTIVE       <= test_reg != bsi_pkg::BSI_TST_IDLE;
		end
	end

	// Diagnostic flags are the latches themselves
	assign LOW_COIL_DIAG    = low_coil_reg;
	assign CONDENSATE_DIAG  = cond_reg;
	assign FAN_FAILURE_DIAG = fan_fail_reg;
	assign lk.fan_cmd       = FAN_ON;

	// ============================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	AST_COND_SAFE:
	assert property (cond_reg |=> !FAN_ON && !WATER_VALVE_OPEN &&
		!COMPRESSOR_ON && !ELEC_HEAT_ON && !OA_DAMPER_OPEN)
	else $error("condensate trip left an output on");

	AST_COND_LATCH:
	assert property (cond_reg && !DIAG_RESET |=> cond_reg)
	else $error("condensate diagnostic cleared without reset");

	AST_COND_SET:
	assert property (condensate_input |=> cond_reg && CONDENSATE_DIAG)
	else $error("condensate trip not latched");

	AST_FREEZE_SAFE:
	assert property (low_coil_reg && !cond_reg |=> !FAN_ON &&
		WATER_VALVE_OPEN && !OA_DAMPER_OPEN)
	else $error("low coil response wrong");

	AST_FREEZE_SET:
	assert property (coil_freeze_input |=> low_coil_reg)
	else $error("freeze trip not latched");

	AST_FREEZE_HOLD:
	assert property (low_coil_reg && coil_freeze_input |=> low_coil_reg)
	else $error("low coil cleared while contact tripped");

	AST_FANFAIL_SAFE:
	assert property (fan_fail_reg && !low_coil_reg |=> !FAN_ON &&
		!WATER_VALVE_OPEN && !OA_DAMPER_OPEN)
	else $error("fan failure did not halt unit");

	AST_GENERIC:
	assert property (##1 GENERIC_OUT == $past(GENERIC_REQ))
	else $error("generic output disturbed");

	AST_OCC_COMM:
	assert property (COMM_OCC_VALID && COMM_OCC_REQ == bsi_pkg::BSI_OCC_UNOCC
		|=> OCC_MODE == bsi_pkg::BSI_OCC_UNOCC)
	else $error("communicated unoccupied ignored");

	AST_OCC_OPEN:
	assert property (COMM_OCC_VALID && COMM_OCC_REQ ==
		bsi_pkg::BSI_OCC_OCCUPIED && !occupancy_or_spare_input
		|=> OCC_MODE == bsi_pkg::BSI_OCC_OCCUPIED)
	else $error("open contact with occupied request not occupied");

	AST_GENERIC_IN:
	assert property (CFG_SPARE_GENERIC && !COMM_OCC_VALID
		|=> OCC_MODE == bsi_pkg::BSI_OCC_OCCUPIED)
	else $error("generic input steered occupancy");

	AST_OVERRIDE:
	assert property (VALVE_OVERRIDE == bsi_pkg::BSI_VOVR_CLOSE && !low_coil_reg
		&& test_reg == bsi_pkg::BSI_TST_IDLE |=> !WATER_VALVE_OPEN)
	else $error("valve override close not applied");

	AST_TEST_STEP:
	assert property (test_reg == bsi_pkg::BSI_TST_IDLE && test_trig
		|=> test_reg == bsi_pkg::BSI_TST_FAN)
	else $error("test did not start");

	COV_COND: cover property (condensate_input ##1 cond_reg);
	COV_AUTO: cover property (low_coil_reg ##1 !low_coil_reg && !DIAG_RESET);
	COV_FANFAIL: cover property (lk.fan_fail_evt);
	COV_TEST: cover property (test_reg == bsi_pkg::BSI_TST_DAMPER ##1
		test_reg == bsi_pkg::BSI_TST_IDLE);

endmodule

// >>> bsi_field_model.sv
// Field contact model: freeze, float, occupancy and fan proof switches.
// Assumes fan_on comes from the device on the same clock.

`timescale 1ns/1ps

module bsi_field_model
(
	// Clock
	input  wire logic       clk,
	// Scenario controls
	input  wire logic       freeze_ok,
	input  wire logic       float_ok,
	input  wire logic       occ_closed,
	input  wire integer     proof_dly,
	// Device side
	input  wire logic       fan_on,
	output logic [3:0]      contact_closed
);
	int run_cnt = 0;

	// Airflow builds only after the fan runs; a zero delay is a broken belt
	always @(posedge clk)
		run_cnt <= fan_on ? run_cnt + 1 : 0;

	// Safety switches are closed while healthy, open on trip
	assign contact_closed = {proof_dly != 0 && run_cnt >= proof_dly,
		occ_closed, float_ok, freeze_ok};
endmodule

// >>> tb_bsi_interlock.sv
// Self-checking bench for the binary input safety interlock.
// Assumes the field model drives all four contact pins.

`timescale 1ns/1ps

module tb_bsi_interlock;
	// ============================================================
	// Stimulus and observed signals
	logic clk = 1'b0, rst_n = 1'b0;
	bsi_pkg::bsi_pol_t pol [4];
	logic spare_gen, fan_r, vlv_r, comp_r, heat_r, damp_r, gen_r;
	logic occ_v, ctest, dreset, freeze_ok, float_ok, occ_closed, btn;
	bsi_pkg::bsi_occ_t occ_rq, occ_mode;
	bsi_pkg::bsi_vovr_t vovr;
	int proof_dly;
	logic [3:0] contacts;
	logic fan_on, vlv, comp, heat, damp, gen_o;
	logic low_coil, cond, fan_fail, spare_st, test_act;
	int err_total = 0;
	int n_tests = 0;
	wire logic [5:0] outs = {fan_on, vlv, comp, heat, damp, gen_o};
	logic [5:0] tst [7] = '{6'h20, 6'h10, 6'h00, 6'h08, 6'h04, 6'h02,
		6'h00};

	// 10 MHz clock
	always #50 clk = ~clk;

	// ============================================================
	// Device and field
	bsi_interlock #(.FAN_PROOF_CYCLES(32'h14), .AUTO_RECOVER_CYCLES(32'h10))
		dut (.CLK(clk), .RST_N(rst_n), .CONTACT_CLOSED(contacts),
		.TEST_BUTTON(btn), .CFG_POL(pol), .CFG_SPARE_GENERIC(spare_gen),
		.FAN_REQ(fan_r), .VALVE_REQ(vlv_r), .COMP_REQ(comp_r),
		.HEAT_REQ(heat_r), .DAMPER_REQ(damp_r), .GENERIC_REQ(gen_r),
		.COMM_OCC_VALID(occ_v), .COMM_OCC_REQ(occ_rq), .COMM_TEST(ctest),
		.VALVE_OVERRIDE(vovr), .DIAG_RESET(dreset), .FAN_ON(fan_on),
		.WATER_VALVE_OPEN(vlv), .COMPRESSOR_ON(comp), .ELEC_HEAT_ON(heat),
		.OA_DAMPER_OPEN(damp), .GENERIC_OUT(gen_o), .OCC_MODE(occ_mode),
		.LOW_COIL_DIAG(low_coil), .CONDENSATE_DIAG(cond),
		.FAN_FAILURE_DIAG(fan_fail), .SPARE_INPUT_STATE(spare_st),
		.TEST_ACTIVE(test_act));
	bsi_field_model field (.clk(clk), .freeze_ok(freeze_ok),
		.float_ok(float_ok), .occ_closed(occ_closed),
		.proof_dly(proof_dly), .fan_on(fan_on), .contact_closed(contacts));

	// ============================================================
	// Helpers
	task step(input int n);
		repeat (n) @(posedge clk);
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Diagnostic reset pulse, one cycle wide
	task clear_diag;
		step(1);
		dreset <= 1'b1;
		step(1);
		dreset <= 1'b0;
	endtask

	task end_of_test;
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, well past the expected run of under 700 cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		err_total++;
		end_of_test;
	end

	// ============================================================
	// Test sequence
	initial
	begin
		bsi_pkg::bsi_occ_t ex;
		pol = '{bsi_pkg::BSI_POL_NC, bsi_pkg::BSI_POL_NC,
			bsi_pkg::BSI_POL_NO, bsi_pkg::BSI_POL_NO};
		{spare_gen, fan_r, vlv_r, comp_r, heat_r, damp_r, gen_r} = 7'h00;
		{occ_v, ctest, dreset, occ_closed, btn} = 5'h00;
		{freeze_ok, float_ok} = 2'h3;
		occ_rq = bsi_pkg::BSI_OCC_OCCUPIED;
		vovr = bsi_pkg::BSI_VOVR_NONE;
		proof_dly = 2;
		step(3);
		#1 chk(outs, 6'h00);
		chk(occ_mode, bsi_pkg::BSI_OCC_OCCUPIED);
		step(1);
		rst_n <= 1'b1;
		{fan_r, vlv_r, comp_r, heat_r, damp_r, gen_r} <= 6'h3F;
		step(8);
		#1 chk(outs, 6'h3F);
		// Float trip, then restore: stays latched until reset
		step(1);
		float_ok <= 1'b0;
		step(8);
		#1 chk(cond, 1'b1);
		chk(outs, 6'h01);
		step(1);
		float_ok <= 1'b1;
		step(8);
		#1 chk({cond, outs[5]}, 2'h2);
		clear_diag;
		step(8);
		#1 chk({cond, outs}, 7'h3F);
		// Freeze trip, latch, then automatic recovery
		step(1);
		freeze_ok <= 1'b0;
		step(8);
		#1 chk(low_coil, 1'b1);
		chk(outs, 6'h11);
		step(1);
		freeze_ok <= 1'b1;
		step(6);
		#1 chk(low_coil, 1'b1);
		step(30);
		#1 chk({low_coil, outs}, 7'h3F);
		// Proof lost while running, then proof never made after start
		step(1);
		proof_dly <= 0;
		step(30);
		#1 chk(fan_fail, 1'b1);
		chk(outs, 6'h01);
		step(1);
		fan_r <= 1'b0;
		clear_diag;
		fan_r <= 1'b1;
		step(10);
		#1 chk(fan_fail, 1'b0);
		step(20);
		#1 chk(fan_fail, 1'b1);
		step(1);
		proof_dly <= 2;
		{fan_r, vlv_r, comp_r, heat_r, damp_r, gen_r} <= 6'h00;
		clear_diag;
		// Occupancy: hardwired state against every communicated request
		for (int h = 0; h < 2; h++)
			for (int c = 0; c < 4; c++)
			begin
				step(1);
				occ_closed <= h[0];
				occ_v <= (c < 3);
				occ_rq <= bsi_pkg::bsi_occ_t'(c % 3);
				ex = (c == 3) ? (h ? bsi_pkg::BSI_OCC_UNOCC :
					bsi_pkg::BSI_OCC_OCCUPIED) : (c == 0 && h == 1) ?
					bsi_pkg::BSI_OCC_STANDBY : bsi_pkg::bsi_occ_t'(c);
				step(6);
				#1 chk(occ_mode, ex);
			end
		step(1);
		spare_gen <= 1'b1;
		occ_v <= 1'b0;
		step(6);
		#1 chk({spare_st, occ_mode}, 3'h4);
		// Not-used and reversed polarity on the float input
		step(1);
		pol[1] <= bsi_pkg::BSI_POL_UNUSED;
		float_ok <= 1'b0;
		step(8);
		#1 chk(cond, 1'b0);
		step(1);
		float_ok <= 1'b1;
		pol[1] <= bsi_pkg::BSI_POL_NO;
		step(8);
		#1 chk(cond, 1'b1);
		step(1);
		pol[1] <= bsi_pkg::BSI_POL_NC;
		clear_diag;
		// Manual test walks every step and back to idle; button and
		// communicated test variable take turns as the trigger
		for (int i = 0; i < 7; i++)
		begin
			step(1);
			if (i[0])
				ctest <= 1'b1;
			else
				btn <= 1'b1;
			step(1);
			{ctest, btn} <= 2'h0;
			step(4);
			#1 chk({test_act, outs}, {i < 6, tst[i]});
		end
		// Valve override beats the normal valve request both ways
		step(1);
		vovr <= bsi_pkg::BSI_VOVR_OPEN;
		step(3);
		#1 chk(outs, 6'h10);
		step(1);
		vlv_r <= 1'b1;
		vovr <= bsi_pkg::BSI_VOVR_CLOSE;
		step(3);
		#1 chk(outs, 6'h00);
		end_of_test;
	end
endmodule
